// ===== logic/bsx_bit_insert.sv
// replaces one selected bit of a word, all other bits pass through
`default_nettype none

module bsx_bit_insert (
	// word, bit index and new bit value
	bsx_bitw_if.unit bw
);

	// one mux per bit; only the indexed bit takes the new value
	for (genvar i = 0; i < bsx_pkg::DATA_W; i++)
	begin : g_bit
		assign bw.word_out[i] = (bw.index == bsx_pkg::BIT_W'(i)) ?
			bw.value : bw.word_in[i];
	end

endmodule // bsx_bit_insert

`default_nettype wire

// ===== logic/bsx_exec_unit.sv
// bit, shift, rotate and flag execution unit of the 8-bit core
`default_nettype none

module bsx_exec_unit (
	// clock and reset
	input  wire logic                               clock,
	input  wire logic                               reset,
	// op request from the decoder
	input  wire logic                               op_valid,
	input  wire bsx_pkg::bsx_op_e                   op_code,
	output logic                                    op_ready,
	// operands from the register file and decoder
	input  wire logic [bsx_pkg::DATA_W-1:0]         dest_data,
	input  wire logic [bsx_pkg::DATA_W-1:0]         src_data,
	input  wire logic [bsx_pkg::BIT_W-1:0]          bit_sel,
	input  wire logic [bsx_pkg::IO_ADDR_W-1:0]      io_addr,
	// destination register write port
	output logic                                    rd_we,
	output logic [bsx_pkg::DATA_W-1:0]              rd_wdata,
	// i/o space read and write ports
	output logic                                    io_rd_en,
	output logic [bsx_pkg::IO_ADDR_W-1:0]           io_rd_addr,
	input  wire logic [bsx_pkg::DATA_W-1:0]         io_rdata,
	output logic                                    io_we,
	output logic [bsx_pkg::IO_ADDR_W-1:0]           io_waddr,
	output logic [bsx_pkg::DATA_W-1:0]              io_wdata,
	// status flags register
	output logic [bsx_pkg::DATA_W-1:0]              status_flags_reg
);

	// whole state of the unit
	typedef struct packed {
		bsx_pkg::bsx_state_e              state;
		logic [bsx_pkg::DATA_W-1:0]       status;
		logic [bsx_pkg::IO_ADDR_W-1:0]    io_addr;
		logic [bsx_pkg::BIT_W-1:0]        bit_sel;
		logic                             set_bit;
	} bsx_core_s;

	localparam bsx_core_s CORE_RST = '{
		state:   bsx_pkg::st_idle,
		status:  bsx_pkg::STATUS_RST,
		io_addr: '0,
		bit_sel: '0,
		set_bit: 1'b0
	};

	bsx_core_s  s_q;
	bsx_core_s  s_d;
	logic       take;

	bsx_shift_if sh ();
	bsx_bitw_if  rb ();
	bsx_bitw_if  ib ();

	// shift network works straight on the destination operand
	assign sh.operand  = dest_data;
	assign sh.carry_in = s_q.status[bsx_pkg::FLAG_C];
	assign sh.op       = op_code;

	bsx_shift_unit u_shift (
		.sh (sh)
	);

	// register bit load inserts the transfer flag
	assign rb.word_in = dest_data;
	assign rb.index   = bit_sel;
	assign rb.value   = s_q.status[bsx_pkg::FLAG_T];

	bsx_bit_insert u_reg_bit (
		.bw (rb)
	);

	// i/o read-modify-write uses the operands latched at acceptance
	assign ib.word_in = io_rdata;
	assign ib.index   = s_q.bit_sel;
	assign ib.value   = s_q.set_bit;

	bsx_bit_insert u_io_bit (
		.bw (ib)
	);

	// ready drops for the second cycle of an i/o op
	assign op_ready = (s_q.state == bsx_pkg::st_idle);
	assign take     = op_valid && op_ready;
	assign status_flags_reg = s_q.status;

	// next state, write strobes and flag updates
	always_comb
	begin
		s_d        = s_q;
		rd_we      = 1'b0;
		rd_wdata   = sh.result;
		io_rd_en   = 1'b0;
		io_rd_addr = io_addr;
		io_we      = 1'b0;
		io_waddr   = s_q.io_addr;
		io_wdata   = ib.word_out;
		case (s_q.state)
			bsx_pkg::st_idle:
			begin
				if (take)
				begin
					case (op_code)
						bsx_pkg::io_bit_set_op,
						bsx_pkg::io_bit_clear_op:
						begin
							// read now, write back next cycle
							io_rd_en      = 1'b1;
							s_d.state     = bsx_pkg::st_io_mod;
							s_d.io_addr   = io_addr;
							s_d.bit_sel   = bit_sel;
							s_d.set_bit   = (op_code == bsx_pkg::io_bit_set_op);
						end
						bsx_pkg::shift_left_logical_op,
						bsx_pkg::shift_right_logical_op,
						bsx_pkg::rotate_left_carry_op,
						bsx_pkg::rotate_right_carry_op,
						bsx_pkg::shift_right_signed_op:
						begin
							rd_we = 1'b1;
							s_d.status[bsx_pkg::FLAG_C] = sh.carry_out;
							s_d.status[bsx_pkg::FLAG_Z] = sh.zero;
							s_d.status[bsx_pkg::FLAG_N] = sh.negative;
							s_d.status[bsx_pkg::FLAG_V] = sh.overflow;
						end
						bsx_pkg::nibble_swap_op:
							rd_we = 1'b1;
						bsx_pkg::flag_set_op:
							s_d.status[bit_sel] = 1'b1;
						bsx_pkg::flag_clear_op:
							s_d.status[bit_sel] = 1'b0;
						bsx_pkg::reg_bit_to_transfer_op:
							s_d.status[bsx_pkg::FLAG_T] = src_data[bit_sel];
						bsx_pkg::transfer_to_reg_bit_op:
						begin
							rd_we    = 1'b1;
							rd_wdata = rb.word_out;
						end
						bsx_pkg::carry_force_one_op:
							s_d.status[bsx_pkg::FLAG_C] = 1'b1;
						bsx_pkg::carry_force_zero_op:
							s_d.status[bsx_pkg::FLAG_C] = 1'b0;
						bsx_pkg::negative_force_one_op:
							s_d.status[bsx_pkg::FLAG_N] = 1'b1;
						bsx_pkg::negative_force_zero_op:
							s_d.status[bsx_pkg::FLAG_N] = 1'b0;
						bsx_pkg::zero_force_one_op:
							s_d.status[bsx_pkg::FLAG_Z] = 1'b1;
						bsx_pkg::zero_force_zero_op:
							s_d.status[bsx_pkg::FLAG_Z] = 1'b0;
						bsx_pkg::irq_global_enable_op:
							s_d.status[bsx_pkg::FLAG_I] = 1'b1;
						bsx_pkg::irq_global_disable_op:
							s_d.status[bsx_pkg::FLAG_I] = 1'b0;
						default:
							s_d = s_q;
					endcase
				end
			end
			bsx_pkg::st_io_mod:
			begin
				// final cycle: write the modified byte, flags untouched
				io_we     = 1'b1;
				s_d.state = bsx_pkg::st_idle;
			end
			default:
				s_d.state = bsx_pkg::st_idle;
		endcase
	end

	// single state register; all updates land at this edge
	always_ff @(posedge clock)
	begin
		if (reset)
			s_q <= CORE_RST;
		else
			s_q <= s_d;
	end

	// checks of the execution behaviour
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	// helper: single-bit mask for the latched i/o bit
	logic [bsx_pkg::DATA_W-1:0] io_mask;
	assign io_mask = bsx_pkg::BIT_ONE << s_q.bit_sel;

	property p_io_two(bsx_pkg::bsx_op_e o);
		take && op_code == o |=> io_we && !op_ready ##1 !io_we && op_ready;
	endproperty

	io_set_len_a: assert property (p_io_two(bsx_pkg::io_bit_set_op))
		else $error("io bit set did not take two cycles");
	io_clr_len_a: assert property (p_io_two(bsx_pkg::io_bit_clear_op))
		else $error("io bit clear did not take two cycles");
	io_set_bit_a: assert property (io_we && s_q.set_bit |->
		io_wdata == (io_rdata | io_mask))
		else $error("io bit set wrote a wrong byte");
	io_clr_bit_a: assert property (io_we && !s_q.set_bit |->
		io_wdata == (io_rdata & ~io_mask))
		else $error("io bit clear wrote a wrong byte");
	io_flags_keep_a: assert property (take && (op_code ==
		bsx_pkg::io_bit_clear_op) |=> $stable(status_flags_reg) [*2])
		else $error("io bit op changed a flag");
	shl_result_a: assert property (take && op_code ==
		bsx_pkg::shift_left_logical_op |-> rd_we &&
		rd_wdata == {dest_data[bsx_pkg::MSB-1:bsx_pkg::LSB], 1'b0})
		else $error("left shift result wrong");
	shr_carry_a: assert property (take && op_code ==
		bsx_pkg::shift_right_logical_op |=> status_flags_reg[bsx_pkg::FLAG_C]
		== $past(dest_data[bsx_pkg::LSB]))
		else $error("right shift carry wrong");
	shr_zero_a: assert property (take && op_code ==
		bsx_pkg::shift_right_logical_op |=> status_flags_reg[bsx_pkg::FLAG_Z]
		== ($past(dest_data[bsx_pkg::MSB:bsx_pkg::LSB+1]) == '0))
		else $error("right shift zero flag wrong");
	rol_in_a: assert property (take && op_code ==
		bsx_pkg::rotate_left_carry_op |-> rd_wdata[bsx_pkg::LSB] ==
		status_flags_reg[bsx_pkg::FLAG_C])
		else $error("left rotate lost the carry");
	ror_in_a: assert property (take && op_code ==
		bsx_pkg::rotate_right_carry_op |-> rd_wdata[bsx_pkg::MSB] ==
		status_flags_reg[bsx_pkg::FLAG_C])
		else $error("right rotate lost the carry");
	asr_sign_a: assert property (take && op_code ==
		bsx_pkg::shift_right_signed_op |-> rd_wdata[bsx_pkg::MSB] ==
		dest_data[bsx_pkg::MSB])
		else $error("signed shift lost the sign");
	swap_flags_a: assert property (take && op_code ==
		bsx_pkg::nibble_swap_op |=> $stable(status_flags_reg))
		else $error("nibble swap changed a flag");
	swap_result_a: assert property (take && op_code ==
		bsx_pkg::nibble_swap_op |-> rd_we && rd_wdata ==
		{dest_data[bsx_pkg::NIB_LO:bsx_pkg::LSB],
		dest_data[bsx_pkg::MSB:bsx_pkg::NIB_HI]})
		else $error("nibble swap result wrong");
	shift_ovf_a: assert property (take && op_code ==
		bsx_pkg::rotate_left_carry_op |=> status_flags_reg[bsx_pkg::FLAG_V] ==
		(status_flags_reg[bsx_pkg::FLAG_N] ^
		status_flags_reg[bsx_pkg::FLAG_C]))
		else $error("overflow is not n xor c");
	flag_set_a: assert property (take && op_code == bsx_pkg::flag_set_op
		|=> status_flags_reg == ($past(status_flags_reg) |
		(bsx_pkg::BIT_ONE << $past(bit_sel))))
		else $error("flag set touched other flags");
	flag_clr_a: assert property (take && op_code ==
		bsx_pkg::flag_clear_op |=> status_flags_reg ==
		($past(status_flags_reg) & ~(bsx_pkg::BIT_ONE << $past(bit_sel))))
		else $error("flag clear touched other flags");
	bit_store_a: assert property (take && op_code ==
		bsx_pkg::reg_bit_to_transfer_op |=> status_flags_reg[bsx_pkg::FLAG_T]
		== $past(src_data[bit_sel]))
		else $error("bit store missed the transfer flag");
	bit_load_a: assert property (take && op_code ==
		bsx_pkg::transfer_to_reg_bit_op |-> rd_we &&
		rd_wdata[bit_sel] == status_flags_reg[bsx_pkg::FLAG_T])
		else $error("bit load wrote a wrong bit");
	carry_one_a: assert property (take && op_code ==
		bsx_pkg::carry_force_one_op |=> status_flags_reg ==
		($past(status_flags_reg) | bsx_pkg::BIT_ONE))
		else $error("carry force one wrong");
	carry_zero_a: assert property (take && op_code ==
		bsx_pkg::carry_force_zero_op |=> status_flags_reg ==
		($past(status_flags_reg) & ~bsx_pkg::BIT_ONE))
		else $error("carry force zero wrong");
	neg_zero_a: assert property (take && op_code ==
		bsx_pkg::negative_force_zero_op |=>
		!status_flags_reg[bsx_pkg::FLAG_N])
		else $error("negative force zero wrong");
	zero_one_a: assert property (take && op_code ==
		bsx_pkg::zero_force_one_op |=> status_flags_reg[bsx_pkg::FLAG_Z])
		else $error("zero force one wrong");
	irq_on_a: assert property (take && op_code ==
		bsx_pkg::irq_global_enable_op |=>
		status_flags_reg[bsx_pkg::FLAG_I])
		else $error("interrupt enable not set");
	irq_off_a: assert property (take && op_code ==
		bsx_pkg::irq_global_disable_op |=>
		!status_flags_reg[bsx_pkg::FLAG_I])
		else $error("interrupt enable not cleared");
	next_sees_a: assert property (take && op_code ==
		bsx_pkg::zero_force_zero_op |=> op_ready &&
		!status_flags_reg[bsx_pkg::FLAG_Z])
		else $error("flag write not seen by next op");

	// main scenarios
	io_set_seen_c: cover property (take && op_code ==
		bsx_pkg::io_bit_set_op ##2 take);
	rol_chain_c: cover property (take && op_code ==
		bsx_pkg::rotate_left_carry_op ##1 take && op_code ==
		bsx_pkg::rotate_left_carry_op);
	store_load_c: cover property (take && op_code ==
		bsx_pkg::reg_bit_to_transfer_op ##1 take && op_code ==
		bsx_pkg::transfer_to_reg_bit_op);
	io_clr_seen_c: cover property (take && op_code ==
		bsx_pkg::io_bit_clear_op ##2 take);

endmodule // bsx_exec_unit

`default_nettype wire

// ===== logic/bsx_links.sv
// interfaces between the core and its shift and bit-insert units
`default_nettype none

interface bsx_shift_if;
	logic [bsx_pkg::DATA_W-1:0] operand;
	logic                       carry_in;
	bsx_pkg::bsx_op_e           op;
	logic [bsx_pkg::DATA_W-1:0] result;
	logic                       carry_out;
	logic                       zero;
	logic                       negative;
	logic                       overflow;

	modport core (output operand, carry_in, op,
		input result, carry_out, zero, negative, overflow);
	modport unit (input operand, carry_in, op,
		output result, carry_out, zero, negative, overflow);
endinterface

interface bsx_bitw_if;
	logic [bsx_pkg::DATA_W-1:0] word_in;
	logic [bsx_pkg::BIT_W-1:0]  index;
	logic                       value;
	logic [bsx_pkg::DATA_W-1:0] word_out;

	modport core (output word_in, index, value, input word_out);
	modport unit (input word_in, index, value, output word_out);
endinterface

`default_nettype wire

// ===== logic/bsx_pkg.sv
// package: widths, flag positions, op codes and states of the bit/shift unit
`default_nettype none

package bsx_pkg;

	// data path widths
	localparam int DATA_W    = 8;
	localparam int BIT_W     = 3;
	localparam int IO_ADDR_W = 6;

	// bit positions inside a data word
	localparam int MSB    = 7;
	localparam int LSB    = 0;
	localparam int NIB_LO = 3;
	localparam int NIB_HI = 4;

	// status flag positions
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;

	// reset and reference values
	localparam logic [DATA_W-1:0] STATUS_RST = 8'h00;
	localparam logic [DATA_W-1:0] DATA_ZERO  = 8'h00;
	localparam logic [DATA_W-1:0] BIT_ONE    = 8'h01;

	// execution length of the read-modify-write I/O ops, in cycles
	localparam int IO_OP_CYCLES = 2;

	// operation codes from the decoder
	typedef enum logic [4:0] {
		op_none                = 5'h00,
		io_bit_set_op          = 5'h01,
		io_bit_clear_op        = 5'h02,
		shift_left_logical_op  = 5'h03,
		shift_right_logical_op = 5'h04,
		rotate_left_carry_op   = 5'h05,
		rotate_right_carry_op  = 5'h06,
		shift_right_signed_op  = 5'h07,
		nibble_swap_op         = 5'h08,
		flag_set_op            = 5'h09,
		flag_clear_op          = 5'h0a,
		reg_bit_to_transfer_op = 5'h0b,
		transfer_to_reg_bit_op = 5'h0c,
		carry_force_one_op     = 5'h0d,
		carry_force_zero_op    = 5'h0e,
		negative_force_one_op  = 5'h0f,
		negative_force_zero_op = 5'h10,
		zero_force_one_op      = 5'h11,
		zero_force_zero_op     = 5'h12,
		irq_global_enable_op   = 5'h13,
		irq_global_disable_op  = 5'h14
	} bsx_op_e;

	// sequencer states, gray along idle -> io_mod -> idle
	typedef enum logic {
		st_idle   = 1'b0,
		st_io_mod = 1'b1
	} bsx_state_e;

endpackage

`default_nettype wire

// ===== logic/bsx_shift_unit.sv
// shift, rotate and swap network with its result flags
`default_nettype none

module bsx_shift_unit (
	// operand in, result and flags out
	bsx_shift_if.unit sh
);

	// carry out keeps the old carry for ops that do not shift
	always_comb
	begin
		sh.result    = sh.operand;
		sh.carry_out = sh.carry_in;
		case (sh.op)
			bsx_pkg::shift_left_logical_op:
				{sh.carry_out, sh.result} = {sh.operand, 1'b0};
			bsx_pkg::shift_right_logical_op:
				{sh.result, sh.carry_out} = {1'b0, sh.operand};
			bsx_pkg::rotate_left_carry_op:
				{sh.carry_out, sh.result} = {sh.operand, sh.carry_in};
			bsx_pkg::rotate_right_carry_op:
				{sh.result, sh.carry_out} = {sh.carry_in, sh.operand};
			bsx_pkg::shift_right_signed_op:
				{sh.result, sh.carry_out} =
					{sh.operand[bsx_pkg::MSB], sh.operand};
			bsx_pkg::nibble_swap_op:
				sh.result = {sh.operand[bsx_pkg::NIB_LO:bsx_pkg::LSB],
					sh.operand[bsx_pkg::MSB:bsx_pkg::NIB_HI]};
			default:
				sh.result = sh.operand;
		endcase
	end

	// flags follow the result, overflow is n xor c
	assign sh.negative = sh.result[bsx_pkg::MSB];
	assign sh.zero     = (sh.result == bsx_pkg::DATA_ZERO);
	assign sh.overflow = sh.negative ^ sh.carry_out;

endmodule // bsx_shift_unit

`default_nettype wire

// ===== verif/bsx_io_space_model.sv
// i/o register space seen by the unit, registered one-cycle read
`default_nettype none

module bsx_io_space_model (
	// clock
	input  wire logic       clock,
	// read port
	input  wire logic       io_rd_en,
	input  wire logic [5:0] io_rd_addr,
	output logic [7:0]      io_rdata,
	// write port
	input  wire logic       io_we,
	input  wire logic [5:0] io_waddr,
	input  wire logic [7:0] io_wdata
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] mem [64];

	// seeded contents, mirrored by the bench
	initial
	begin
		io_rdata = 8'h00;
		for (int i = 0; i < 64; i++)
			mem[i] = 8'ha5 ^ 8'(i);
	end

	// no read pending: show the inverse, never a stale byte
	always @(posedge clock)
	begin
		if (io_rd_en)
			io_rdata <= mem[io_rd_addr];
		else
			io_rdata <= ~io_rdata;
		if (io_we)
			mem[io_waddr] <= io_wdata;
	end
endmodule // bsx_io_space_model

`default_nettype wire

// ===== verif/tb_bsx_exec_unit.sv
// self-checking bench for the bit, shift and flag execution unit
`default_nettype none

module tb_bsx_exec_unit;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int CYCLE_LIMIT = 5000;

	// design ports
	logic             clock     = 1'b0;
	logic             reset     = 1'b1;
	logic             op_valid  = 1'b0;
	bsx_pkg::bsx_op_e op_code   = bsx_pkg::op_none;
	logic [7:0]       dest_data = 8'h00;
	logic [7:0]       src_data  = 8'h00;
	logic [2:0]       bit_sel   = 3'h0;
	logic [5:0]       io_addr   = 6'h00;
	logic             op_ready;
	logic             rd_we;
	logic [7:0]       rd_wdata;
	logic             io_rd_en;
	logic [5:0]       io_rd_addr;
	logic [7:0]       io_rdata;
	logic             io_we;
	logic [5:0]       io_waddr;
	logic [7:0]       io_wdata;
	logic [7:0]       status_flags_reg;

	// reference state and bookkeeping
	logic [7:0] sf_m = 8'h00;
	logic [7:0] io_m [64];
	int         bad_count  = 0;
	int         num_checks = 0;
	int         cyc        = 0;
	int         seed       = 56;

	always #4 clock = ~clock;

	bsx_exec_unit u_bsx_exec_unit (
		.clock(clock), .reset(reset), .op_valid(op_valid),
		.op_code(op_code), .op_ready(op_ready), .dest_data(dest_data),
		.src_data(src_data), .bit_sel(bit_sel), .io_addr(io_addr),
		.rd_we(rd_we), .rd_wdata(rd_wdata), .io_rd_en(io_rd_en),
		.io_rd_addr(io_rd_addr), .io_rdata(io_rdata), .io_we(io_we),
		.io_waddr(io_waddr), .io_wdata(io_wdata),
		.status_flags_reg(status_flags_reg)
	);

	bsx_io_space_model u_bsx_io_space_model (
		.clock(clock), .io_rd_en(io_rd_en), .io_rd_addr(io_rd_addr),
		.io_rdata(io_rdata), .io_we(io_we), .io_waddr(io_waddr),
		.io_wdata(io_wdata)
	);

	// verdict and end of run
	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// byte and single-bit comparisons
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp,
		input string what);
		num_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, what,
				got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp, input string what);
		chk_byte({7'h00, got}, {7'h00, exp}, what);
	endtask

	// corner values turn up often: zero, sign only, lsb only, all ones
	function automatic logic [7:0] pick();
		logic [31:0] v;
		logic [7:0]  corner [4];
		corner = '{8'h00, 8'h80, 8'h01, 8'hff};
		v = $random(seed);
		return (v[9:8] == 2'h0) ? corner[v[1:0]] : v[7:0];
	endfunction

	// one op, driven at a rising edge, checked against the model
	task automatic run_op(input int k, input logic [7:0] d, input logic [7:0] s,
		input logic [2:0] b, input logic [5:0] a);
		bsx_pkg::bsx_op_e op;
		logic [7:0]       r;
		logic             c;
		logic             we;
		logic             io;
		op = bsx_pkg::bsx_op_e'(k);
		r = d;
		c = sf_m[0];
		we = 1'b1;
		io = (op == bsx_pkg::io_bit_set_op || op == bsx_pkg::io_bit_clear_op);
		case (op)
			bsx_pkg::shift_left_logical_op:  {c, r} = {d, 1'b0};
			bsx_pkg::shift_right_logical_op: {r, c} = {1'b0, d};
			bsx_pkg::rotate_left_carry_op:   {c, r} = {d, sf_m[0]};
			bsx_pkg::rotate_right_carry_op:  {r, c} = {sf_m[0], d};
			bsx_pkg::shift_right_signed_op:  {r, c} = {d[7], d};
			bsx_pkg::nibble_swap_op:         r = {d[3:0], d[7:4]};
			bsx_pkg::transfer_to_reg_bit_op: r[b] = sf_m[6];
			default:                         we = 1'b0;
		endcase
		op_valid <= 1'b1;
		op_code <= op;
		dest_data <= d;
		src_data <= s;
		bit_sel <= b;
		io_addr <= a;
		@(negedge clock);
		chk_byte(status_flags_reg, sf_m, "flags");
		chk_bit(op_ready, 1'b1, "ready");
		chk_bit(rd_we, we, "rd_we");
		if (we)
			chk_byte(rd_wdata, r, "rd_wdata");
		chk_bit(io_rd_en, io, "io_rd_en");
		chk_bit(io_we, 1'b0, "io_we early");
		if (io)
			chk_byte({2'h0, io_rd_addr}, {2'h0, a}, "io_rd_addr");
		@(posedge clock);
		if (op >= bsx_pkg::shift_left_logical_op &&
			op <= bsx_pkg::shift_right_signed_op)
			sf_m[3:0] = {r[7] ^ c, r[7], r == 8'h00, c};
		case (op)
			bsx_pkg::flag_set_op:            sf_m[b] = 1'b1;
			bsx_pkg::flag_clear_op:          sf_m[b] = 1'b0;
			bsx_pkg::reg_bit_to_transfer_op: sf_m[6] = s[b];
			bsx_pkg::carry_force_one_op:     sf_m[0] = 1'b1;
			bsx_pkg::carry_force_zero_op:    sf_m[0] = 1'b0;
			bsx_pkg::negative_force_one_op:  sf_m[2] = 1'b1;
			bsx_pkg::negative_force_zero_op: sf_m[2] = 1'b0;
			bsx_pkg::zero_force_one_op:      sf_m[1] = 1'b1;
			bsx_pkg::zero_force_zero_op:     sf_m[1] = 1'b0;
			bsx_pkg::irq_global_enable_op:   sf_m[7] = 1'b1;
			bsx_pkg::irq_global_disable_op:  sf_m[7] = 1'b0;
			default:                         ;
		endcase
		if (io)
		begin
			// offered while busy, so it must be ignored
			op_code <= (sf_m[0]) ? bsx_pkg::carry_force_zero_op
				: bsx_pkg::carry_force_one_op;
			r = io_m[a];
			r[b] = (op == bsx_pkg::io_bit_set_op);
			@(negedge clock);
			chk_bit(op_ready, 1'b0, "busy ready");
			chk_bit(io_we, 1'b1, "io_we");
			chk_byte({2'h0, io_waddr}, {2'h0, a}, "io_waddr");
			chk_byte(io_wdata, r, "io_wdata");
			io_m[a] = r;
			@(posedge clock);
		end
	endtask

	// random ops over every code
	task automatic run_random(input int count);
		logic [31:0] v;
		for (int n = 0; n < count; n++)
		begin
			v = $random(seed);
			run_op(int'(v[15:0] % 21), pick(), pick(), v[18:16], v[24:19]);
		end
	endtask

	// hang guard
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (cyc == CYCLE_LIMIT)
		begin
			bad_count++;
			test_done;
		end
	end

	initial
	begin
		for (int i = 0; i < 64; i++)
			io_m[i] = 8'ha5 ^ 8'(i);
		repeat (10) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		for (int k = 0; k < 21; k++)
			run_op(k, pick(), pick(), 3'(k), 6'(k));
		run_random(400);
		// second reset in mid-run clears the flags
		reset <= 1'b1;
		op_valid <= 1'b0;
		@(negedge clock);
		chk_bit(rd_we, 1'b0, "rd_we in reset");
		@(posedge clock);
		reset <= 1'b0;
		sf_m = 8'h00;
		@(negedge clock);
		chk_bit(op_ready, 1'b1, "ready after reset");
		chk_byte(status_flags_reg, sf_m, "flags after reset");
		@(posedge clock);
		run_random(200);
		op_valid <= 1'b0;
		@(negedge clock);
		chk_byte(status_flags_reg, sf_m, "final flags");
		test_done;
	end
endmodule // tb_bsx_exec_unit

`default_nettype wire
